/* core/ppf_defines.svh */
// constants for the parallel printer port with output buffer
`ifndef PPF_DEFINES_SVH
`define PPF_DEFINES_SVH

`define PPF_DW 8
`define PPF_FIFO_DEPTH 83
`define PPF_FIFO_CW 7

// register select values
`define PPF_SEL_PORT 2'h0
`define PPF_SEL_STATUS 2'h1
`define PPF_SEL_CMD 2'h2
`define PPF_SEL_COUNT 2'h3
`define PPF_SEL_CTRL 2'h1
`define PPF_SEL_AFR 2'h2

// control register fields
`define PPF_CTL_STROBE 0
`define PPF_CTL_AUTOFD 1
`define PPF_CTL_RESTART 2
`define PPF_CTL_CHOOSE 3
`define PPF_CTL_IRQ_EN 4
`define PPF_CTL_DIR_IN 5

// alternate function register fields
`define PPF_AFR_WIDTH_HI 2
`define PPF_AFR_WIDTH_LO 0
`define PPF_AFR_BUSY_HS 3
`define PPF_AFR_IRQ_INV 6
`define PPF_AFR_FIFO_EN 7

// reset values
`define PPF_PORT_RESET 8'h00
`define PPF_CTL_RESET 8'h04
`define PPF_AFR_RESET 8'h00
`define PPF_PINS_IDLE 32'h70025f00

// read-back fill bits
`define PPF_STAT_FILL 2'h3
`define PPF_CMD_FILL 3'h7

// strobe timing: width is (afr width field + 1) units
`define PPF_CLK_NS 40
`define PPF_STB_UNIT_NS 1000
`define PPF_STB_UNIT_CYC ((`PPF_STB_UNIT_NS + `PPF_CLK_NS - 1) / `PPF_CLK_NS)
`define PPF_STB_CW 8

`endif

/* core/ppf_pkg.sv */
// types for the parallel printer port with output buffer
package ppf_pkg;

    typedef enum logic [1:0] {
        drn_idle = 2'h0,
        drn_pulse = 2'h1,
        drn_wait = 2'h3
    } ppf_drain_e;

    typedef struct packed {
        logic master_reset;
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic [1:0] sel;
        logic [7:0] hbus;
        logic fault_n;
        logic online;
        logic busy;
        logic ack_n;
        logic paper_out;
        logic irq_style;
        logic strobe_pin;
        logic autofd_pin;
        logic restart_pin;
        logic choose_pin;
        logic [7:0] port;
    } ppf_pins_s;

endpackage

/* core/ppf_fifo.sv */
// output byte buffer with registered read stage
module ppf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 83,
    parameter int CW = 7
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic clear_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in,
    output logic [CW-1:0] count_out
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [CW-1:0] wr_ptr_q;
    logic [CW-1:0] rd_ptr_q;
    logic [CW-1:0] mem_cnt_q;
    logic [CW-1:0] count_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic push;
    logic pop;
    logic load;

    function automatic logic [CW-1:0] next_ptr(input logic [CW-1:0] p);
        next_ptr = (p == CW'(DEPTH - 1)) ? '0 : p + CW'(1);
    endfunction

    // count includes the output stage, so full means DEPTH bytes held
    assign in_ready_out = (count_q != CW'(DEPTH));
    assign push = in_valid_in && in_ready_out && !clear_in;
    assign pop = out_valid_q && out_ready_in;
    assign load = (mem_cnt_q != '0) && (!out_valid_q || pop);

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            mem_cnt_q <= '0;
            count_q <= '0;
        end else if (clear_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            mem_cnt_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= next_ptr(wr_ptr_q);
            end
            if (load) begin
                rd_ptr_q <= next_ptr(rd_ptr_q);
            end
            mem_cnt_q <= mem_cnt_q + CW'(push) - CW'(load);
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (clear_in) begin
            out_valid_q <= 1'b0;
        end else if (load) begin
            out_valid_q <= 1'b1;
            out_data_q <= mem_q[rd_ptr_q];
        end else if (pop) begin
            out_valid_q <= 1'b0;
        end
    end

    assign out_valid_out = out_valid_q;
    assign out_data_out = out_data_q;
    assign count_out = count_q;

endmodule

/* core/ppf_port.sv */
// parallel printer port top: host registers, printer handshake, output buffer
`include "ppf_defines.svh"

module ppf_port (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic master_reset_in,
    input wire logic host_cs_n_in,
    input wire logic host_wr_n_in,
    input wire logic host_rd_n_in,
    input wire logic [1:0] reg_sel_in,
    input wire logic [`PPF_DW-1:0] host_bus_in,
    output logic [`PPF_DW-1:0] host_bus_out,
    output logic host_bus_oe_out,
    input wire logic [`PPF_DW-1:0] port_lines_in,
    output logic [`PPF_DW-1:0] port_lines_out,
    output logic port_lines_oe_out,
    input wire logic data_pulse_n_in,
    output logic data_pulse_n_out,
    output logic data_pulse_n_oe_out,
    input wire logic line_feed_auto_n_in,
    output logic line_feed_auto_n_out,
    output logic line_feed_auto_n_oe_out,
    input wire logic printer_restart_in,
    output logic printer_restart_out,
    output logic printer_restart_oe_out,
    input wire logic printer_choose_n_in,
    output logic printer_choose_n_out,
    output logic printer_choose_n_oe_out,
    input wire logic printer_fault_n_in,
    input wire logic printer_online_in,
    input wire logic busy_in,
    input wire logic ack_n_in,
    input wire logic paper_out_in,
    input wire logic irq_style_pin_in,
    output logic irq_line_out,
    output logic irq_line_oe_out
);
    ppf_pkg::ppf_pins_s pins_raw;
    ppf_pkg::ppf_pins_s s1_q;
    ppf_pkg::ppf_pins_s s2_q;
    ppf_pkg::ppf_pins_s s3_q;
    ppf_pkg::ppf_pins_s pins_q;
    ppf_pkg::ppf_drain_e drn_q;

    logic [`PPF_DW-1:0] port_q;
    logic [`PPF_DW-1:0] ctrl_q;
    logic [`PPF_DW-1:0] afr_q;
    logic [`PPF_DW-1:0] rd_data_q;
    logic [`PPF_DW-1:0] port_out_q;
    logic [`PPF_DW-1:0] status;
    logic [`PPF_DW-1:0] command;
    logic [`PPF_DW-1:0] rd_mux;
    logic [`PPF_STB_CW-1:0] stb_cnt_q;
    logic [`PPF_STB_CW-1:0] stb_len;
    logic [`PPF_FIFO_CW-1:0] fifo_count;
    logic [`PPF_DW-1:0] fifo_head;
    logic wr_act_q, rd_act_q, ack_prev_q, busy_prev_q, fifo_mode_q, strobe_seen_q;
    logic irq_latch_q, rd_oe_q, strobe_oe_q, irq_q, irq_oe_q;
    logic mrst, wr_act, rd_act, wr_fire, rd_fire, restart_low, fifo_en, fifo_clr;
    logic hs_lvl, hs_fall, fifo_push, fifo_ready, fifo_valid, fifo_pop, stat_read, irq_assert;

    assign pins_raw = {master_reset_in, host_cs_n_in, host_wr_n_in, host_rd_n_in, reg_sel_in, host_bus_in,
        printer_fault_n_in, printer_online_in, busy_in, ack_n_in, paper_out_in, irq_style_pin_in,
        data_pulse_n_in, line_feed_auto_n_in, printer_restart_in, printer_choose_n_in, port_lines_in};

    // three-stage sampling; a bit is accepted once stages two and three agree
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_q <= `PPF_PINS_IDLE;
            s2_q <= `PPF_PINS_IDLE;
            s3_q <= `PPF_PINS_IDLE;
            pins_q <= `PPF_PINS_IDLE;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < $bits(ppf_pkg::ppf_pins_s); i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    pins_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign mrst = pins_q.master_reset;
    assign wr_act = !pins_q.cs_n && !pins_q.wr_n;
    assign rd_act = !pins_q.cs_n && !pins_q.rd_n;
    assign wr_fire = wr_act && !wr_act_q;
    assign rd_fire = rd_act && !rd_act_q;
    assign stat_read = rd_fire && (pins_q.sel == `PPF_SEL_STATUS);
    // pin read-back covers both our own drive and an external pull-down
    assign restart_low = !pins_q.restart_pin;
    assign fifo_en = afr_q[`PPF_AFR_FIFO_EN];
    assign fifo_clr = mrst || restart_low || !fifo_en;
    assign hs_lvl = afr_q[`PPF_AFR_BUSY_HS] ? pins_q.busy : pins_q.ack_n;
    // one detector per input: switching the handshake source makes no false edge
    assign hs_fall = (afr_q[`PPF_AFR_BUSY_HS] ? busy_prev_q : ack_prev_q) && !hs_lvl;
    assign fifo_push = wr_fire && (pins_q.sel == `PPF_SEL_PORT) && fifo_en;
    assign stb_len = `PPF_STB_CW'((int'(afr_q[`PPF_AFR_WIDTH_HI:`PPF_AFR_WIDTH_LO]) + 1) * `PPF_STB_UNIT_CYC);

    // take the head byte only when the printer has acknowledged it
    assign fifo_pop = fifo_valid && hs_fall && !restart_low &&
        (fifo_mode_q ? (drn_q == ppf_pkg::drn_wait) : strobe_seen_q);

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            ack_prev_q <= 1'b1;
            busy_prev_q <= 1'b0;
        end else begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            ack_prev_q <= pins_q.ack_n;
            busy_prev_q <= pins_q.busy;
        end
    end

    // host register writes
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            port_q <= `PPF_PORT_RESET;
            ctrl_q <= `PPF_CTL_RESET;
            afr_q <= `PPF_AFR_RESET;
        end else if (mrst) begin
            port_q <= `PPF_PORT_RESET;
            ctrl_q <= `PPF_CTL_RESET;
            afr_q <= `PPF_AFR_RESET;
        end else if (wr_fire) begin
            case (pins_q.sel)
                `PPF_SEL_PORT: begin
                    if (!fifo_en) begin
                        port_q <= pins_q.hbus;
                    end
                end
                `PPF_SEL_CTRL: begin
                    ctrl_q <= pins_q.hbus;
                end
                `PPF_SEL_AFR: begin
                    afr_q <= pins_q.hbus;
                end
                default: begin
                end
            endcase
        end
    end

    ppf_fifo #(
        .WIDTH(`PPF_DW),
        .DEPTH(`PPF_FIFO_DEPTH),
        .CW(`PPF_FIFO_CW)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .clear_in(fifo_clr),
        .in_valid_in(fifo_push),
        .in_data_in(pins_q.hbus),
        .in_ready_out(fifo_ready),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_head),
        .out_ready_in(fifo_pop),
        .count_out(fifo_count)
    );

    // buffered mode is entered on the first acknowledged host strobe
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fifo_mode_q <= 1'b0;
            strobe_seen_q <= 1'b0;
        end else if (fifo_clr) begin
            fifo_mode_q <= 1'b0;
            strobe_seen_q <= 1'b0;
        end else if (!fifo_mode_q) begin
            if (!pins_q.strobe_pin) begin
                strobe_seen_q <= 1'b1;
            end
            if (fifo_pop) begin
                fifo_mode_q <= 1'b1;
            end
        end
    end

    // automatic drain: present head, pulse strobe, wait for the handshake
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            drn_q <= ppf_pkg::drn_idle;
            stb_cnt_q <= '0;
        end else if (fifo_clr || !fifo_mode_q) begin
            drn_q <= ppf_pkg::drn_idle;
            stb_cnt_q <= '0;
        end else begin
            case (drn_q)
                ppf_pkg::drn_idle: begin
                    // a busy printer holds off the next byte
                    if (fifo_valid && !pins_q.busy) begin
                        drn_q <= ppf_pkg::drn_pulse;
                        stb_cnt_q <= stb_len;
                    end
                end
                ppf_pkg::drn_pulse: begin
                    stb_cnt_q <= stb_cnt_q - `PPF_STB_CW'(1);
                    if (stb_cnt_q == `PPF_STB_CW'(1)) begin
                        drn_q <= ppf_pkg::drn_wait;
                    end
                end
                ppf_pkg::drn_wait: begin
                    if (hs_fall) begin
                        drn_q <= ppf_pkg::drn_idle;
                    end
                end
                default: begin
                    drn_q <= ppf_pkg::drn_idle;
                end
            endcase
        end
    end

    // interrupt latch: set on handshake edge wins over the status-read clear
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_latch_q <= 1'b0;
        end else if (mrst) begin
            irq_latch_q <= 1'b0;
        end else if (hs_fall) begin
            irq_latch_q <= 1'b1;
        end else if (stat_read) begin
            irq_latch_q <= 1'b0;
        end
    end

    assign irq_assert = pins_q.irq_style ? !pins_q.ack_n : irq_latch_q;

    assign status = {fifo_en ? fifo_ready : !pins_q.busy, pins_q.ack_n, pins_q.paper_out,
        pins_q.online, pins_q.fault_n, !irq_latch_q, `PPF_STAT_FILL};
    assign command = {`PPF_CMD_FILL, ctrl_q[`PPF_CTL_IRQ_EN], !pins_q.choose_pin,
        pins_q.restart_pin, !pins_q.autofd_pin, !pins_q.strobe_pin};

    always_comb begin
        case (pins_q.sel)
            `PPF_SEL_PORT: rd_mux = ctrl_q[`PPF_CTL_DIR_IN] ? pins_q.port : port_q;
            `PPF_SEL_STATUS: rd_mux = status;
            `PPF_SEL_CMD: rd_mux = command;
            `PPF_SEL_COUNT: rd_mux = {1'b0, fifo_count};
            default: rd_mux = '0;
        endcase
    end

    // pin-facing outputs come from flip-flops, apart from the open-drain data levels tied to 0
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_data_q <= '0;
            rd_oe_q <= 1'b0;
            port_out_q <= `PPF_PORT_RESET;
            strobe_oe_q <= 1'b0;
            irq_q <= 1'b1;
            irq_oe_q <= 1'b0;
        end else if (mrst) begin
            rd_data_q <= '0;
            rd_oe_q <= 1'b0;
            port_out_q <= `PPF_PORT_RESET;
            strobe_oe_q <= 1'b0;
            irq_q <= 1'b1;
            irq_oe_q <= 1'b0;
        end else begin
            rd_data_q <= rd_mux;
            rd_oe_q <= rd_act;
            port_out_q <= fifo_en ? fifo_head : port_q;
            // restart held low forces the strobe released
            strobe_oe_q <= !restart_low && (fifo_mode_q ? (drn_q == ppf_pkg::drn_pulse) :
                ctrl_q[`PPF_CTL_STROBE]);
            irq_q <= afr_q[`PPF_AFR_IRQ_INV] ? irq_assert : !irq_assert;
            irq_oe_q <= ctrl_q[`PPF_CTL_IRQ_EN];
        end
    end

    assign host_bus_out = rd_data_q;
    assign host_bus_oe_out = rd_oe_q;
    assign port_lines_out = port_out_q;
    assign port_lines_oe_out = !ctrl_q[`PPF_CTL_DIR_IN];
    assign data_pulse_n_out = 1'b0;
    assign data_pulse_n_oe_out = strobe_oe_q;
    assign line_feed_auto_n_out = 1'b0;
    assign line_feed_auto_n_oe_out = ctrl_q[`PPF_CTL_AUTOFD];
    assign printer_restart_out = 1'b0;
    assign printer_restart_oe_out = !ctrl_q[`PPF_CTL_RESTART];
    assign printer_choose_n_out = 1'b0;
    assign printer_choose_n_oe_out = ctrl_q[`PPF_CTL_CHOOSE];
    assign irq_line_out = irq_q;
    assign irq_line_oe_out = irq_oe_q;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);

    fifo_depth_a: assert property (
        fifo_count <= `PPF_FIFO_CW'(`PPF_FIFO_DEPTH) && (fifo_ready == (fifo_count != `PPF_FIFO_CW'(`PPF_FIFO_DEPTH))))
        else $error("buffer count out of range");
    direct_port_a: assert property (
        wr_fire && !mrst && pins_q.sel == `PPF_SEL_PORT && !fifo_en |=> ##1 port_out_q == $past(pins_q.hbus, 2))
        else $error("direct write not on port lines");
    restart_clear_a: assert property (
        restart_low |=> fifo_count == '0 && !fifo_valid && !fifo_mode_q)
        else $error("buffer not cleared by restart");
    mode_entry_a: assert property (
        $rose(fifo_mode_q) |-> $past(hs_fall) && $past(strobe_seen_q) && $past(fifo_en))
        else $error("buffered mode entered without acknowledged strobe");
    handshake_pop_a: assert property (
        fifo_mode_q && drn_q == ppf_pkg::drn_wait && hs_fall && fifo_valid && !fifo_clr |-> fifo_pop
        ##1 drn_q == ppf_pkg::drn_idle)
        else $error("handshake edge did not take a byte");
    pulse_width_a: assert property (
        drn_q == ppf_pkg::drn_idle ##1 drn_q == ppf_pkg::drn_pulse && !fifo_clr && fifo_mode_q
        |=> data_pulse_n_oe_out || restart_low)
        else $error("strobe not driven during pulse");
    irq_follow_a: assert property (
        ##1 pins_q.irq_style && !afr_q[`PPF_AFR_IRQ_INV] && !mrst && $stable(afr_q) |=> irq_line_out == $past(pins_q.ack_n))
        else $error("unlatched irq does not follow acknowledge");
    latch_release_a: assert property (
        stat_read && !hs_fall && !mrst |=> !irq_latch_q)
        else $error("status read did not release irq");
    latch_set_a: assert property (
        hs_fall && !mrst |=> irq_latch_q)
        else $error("handshake edge lost by irq latch");
    bus_idle_a: assert property (
        pins_q.cs_n [*2] |-> !host_bus_oe_out)
        else $error("bus driven without chip select");
    full_drop_a: assert property (
        fifo_push && !fifo_ready && !fifo_pop && !fifo_clr |=> fifo_count == $past(fifo_count))
        else $error("write to full buffer counted");
    master_reset_a: assert property (
        mrst |=> ctrl_q == `PPF_CTL_RESET && afr_q == `PPF_AFR_RESET && !irq_latch_q && fifo_count == '0)
        else $error("master reset left state");

endmodule

/* bench/ppf_printer_model.sv */
// behavioural printer on the far side of the port
module ppf_printer_model (
    input wire logic clk_sys_in,
    input wire logic strobe_n_in,
    input wire logic [7:0] data_in,
    output logic ack_n_out,
    output logic busy_out,
    output logic fault_n_out,
    output logic online_out,
    output logic paper_out_out,
    output logic [7:0] rx_count_out,
    output logic [23:0] rx_bytes_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ack only after strobe release, so a held strobe never hides the next pulse
    initial begin
        ack_n_out = 1'b1;
        busy_out = 1'b0;
        fault_n_out = 1'b1;
        online_out = 1'b1;
        paper_out_out = 1'b0;
        rx_count_out = 8'h00;
        rx_bytes_out = 24'h000000;
        forever begin
            @(negedge strobe_n_in);
            rx_bytes_out <= {rx_bytes_out[15:0], data_in};
            rx_count_out <= rx_count_out + 8'h01;
            busy_out <= 1'b1;
            @(posedge strobe_n_in);
            repeat (4) @(posedge clk_sys_in);
            ack_n_out <= 1'b0;
            repeat (6) @(posedge clk_sys_in);
            ack_n_out <= 1'b1;
            busy_out <= 1'b0;
        end
    end
endmodule

/* bench/tb_ppf_port.sv */
// self-checking bench for the printer port
module tb_ppf_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n = 1'b0, mrst = 1'b0, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, style = 1'b1;
    logic [1:0] reg_sel = 2'h0;
    logic [7:0] hbus = 8'h00, port_drv = 8'h00, hb_out, pl_out, rv, rx_n;
    logic hb_oe, pl_oe, stb_oe, stb_o, afd_oe, afd_o, rst_oe, rst_o, cho_oe, cho_o, irq, irq_oe;
    logic ack_n, busy, fault_n, online, paper;
    logic [23:0] rx_b;
    int n_fail = 0, n_tests = 0;
    // open-drain wires with pull-ups, port lines shared with the bench
    wire logic stb_w = stb_oe ? stb_o : 1'b1;
    wire logic afd_w = afd_oe ? afd_o : 1'b1;
    wire logic rst_w = rst_oe ? rst_o : 1'b1;
    wire logic cho_w = cho_oe ? cho_o : 1'b1;
    wire logic [7:0] pl_w = pl_oe ? pl_out : port_drv;
    always #20 clk = ~clk;

    ppf_port i_dut (.clk_sys_in(clk), .arst_n_in(arst_n), .master_reset_in(mrst), .host_cs_n_in(cs_n),
        .host_wr_n_in(wr_n), .host_rd_n_in(rd_n), .reg_sel_in(reg_sel), .host_bus_in(hbus),
        .host_bus_out(hb_out), .host_bus_oe_out(hb_oe), .port_lines_in(pl_w), .port_lines_out(pl_out),
        .port_lines_oe_out(pl_oe), .data_pulse_n_in(stb_w), .data_pulse_n_out(stb_o),
        .data_pulse_n_oe_out(stb_oe), .line_feed_auto_n_in(afd_w), .line_feed_auto_n_out(afd_o),
        .line_feed_auto_n_oe_out(afd_oe), .printer_restart_in(rst_w), .printer_restart_out(rst_o),
        .printer_restart_oe_out(rst_oe), .printer_choose_n_in(cho_w), .printer_choose_n_out(cho_o),
        .printer_choose_n_oe_out(cho_oe), .printer_fault_n_in(fault_n), .printer_online_in(online),
        .busy_in(busy), .ack_n_in(ack_n), .paper_out_in(paper), .irq_style_pin_in(style),
        .irq_line_out(irq), .irq_line_oe_out(irq_oe));

    ppf_printer_model i_prn (.clk_sys_in(clk), .strobe_n_in(stb_w), .data_in(pl_w), .ack_n_out(ack_n),
        .busy_out(busy), .fault_n_out(fault_n), .online_out(online), .paper_out_out(paper),
        .rx_count_out(rx_n), .rx_bytes_out(rx_b));

    task automatic end_sim();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // strobes go through a synchroniser: select held 5 cycles ahead, strobe low at least 6
    task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] wd, input logic cs,
                       output logic [7:0] d);
        int k;
        @(posedge clk);
        reg_sel <= s;
        hbus <= wd;
        repeat (5) @(posedge clk);
        cs_n <= cs;
        wr_n <= !w;
        rd_n <= w;
        for (k = 0; k < 6 || (!w && hb_oe !== 1'b1 && k < 30); k++) @(negedge clk);
        // a released bus must not pass for valid read data
        d = hb_oe ? hb_out : ~hb_out;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    task automatic wr(input logic [1:0] s, input logic [7:0] wd);
        logic [7:0] d;
        acc(1'b1, s, wd, 1'b0, d);
    endtask

    task automatic rdc(input logic [1:0] s, input logic [7:0] exp);
        logic [7:0] d;
        acc(1'b0, s, 8'h00, 1'b0, d);
        chk(d, exp);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({pl_oe, irq, hb_oe, irq_oe}, 4'hc);
        rdc(2'h2, 8'he4);
        wr(2'h0, 8'ha5);
        rdc(2'h0, 8'ha5);
        chk(pl_w, 8'ha5);
        acc(1'b1, 2'h0, 8'h3c, 1'b1, rv);
        rdc(2'h0, 8'ha5);
        chk(hb_oe, 1'b0);
        wr(2'h1, 8'h24);
        port_drv <= 8'h5a;
        chk(pl_oe, 1'b0);
        rdc(2'h0, 8'h5a);
        wr(2'h1, 8'h04);
        // one write past full must be dropped
        wr(2'h2, 8'h80);
        for (int i = 0; i < 84; i++) wr(2'h0, 8'(i));
        rdc(2'h3, 8'h53);
        rdc(2'h1, 8'h5f);
        wr(2'h1, 8'h00);
        wr(2'h1, 8'h04);
        rdc(2'h3, 8'h00);
        style <= 1'b0;
        wr(2'h0, 8'h11);
        wr(2'h0, 8'h22);
        wr(2'h0, 8'h33);
        wr(2'h1, 8'h15);
        wr(2'h1, 8'h14);
        repeat (800) @(posedge clk);
        chk(rx_n, 8'h03);
        chk(rx_b, 24'h112233);
        rdc(2'h3, 8'h00);
        chk({irq_oe, irq}, 2'h2);
        rdc(2'h1, 8'hdb);
        chk(irq, 1'b1);
        rdc(2'h1, 8'hdf);
        wr(2'h2, 8'hc0);
        chk(irq, 1'b0);
        wr(2'h1, 8'h0e);
        rdc(2'h2, 8'hee);
        chk({afd_w, cho_w}, 2'h0);
        // mid-run master reset; the pin is synchronised, so hold it well past the chain
        mrst <= 1'b1;
        repeat (8) @(posedge clk);
        mrst <= 1'b0;
        repeat (8) @(posedge clk);
        chk({pl_oe, irq, hb_oe, irq_oe, afd_w, cho_w}, 6'h33);
        rdc(2'h2, 8'he4);
        // busy as handshake, unlatched interrupt
        style <= 1'b1;
        wr(2'h2, 8'h88);
        wr(2'h0, 8'h44);
        wr(2'h0, 8'h55);
        wr(2'h1, 8'h15);
        wr(2'h1, 8'h14);
        repeat (400) @(posedge clk);
        chk(rx_n, 8'h05);
        chk(rx_b, 24'h334455);
        rdc(2'h3, 8'h00);
        chk({irq_oe, irq}, 2'h3);
        end_sim();
    end
endmodule
